/* File: hdl/rcpc_ctrl.sv */
// Notes on behaviour
// [R1] Usage mode field 1:0: single, alternate frame, split frame, checkerboard; resets 00.
// [R2] Basic split: all units checkerboard except tiler; split via scissor ranges.
// [R3] Statistics counters run continuously; software only clears them at context creation.
// [R4] Counter writes arrive only via immediate, memory or register load commands.
// [R5] Counters readable any time; consistent only after a pipeline flush.
// [R6] Per-stream copies 0..3 of prims written, storage needed and write offset.
// [R7] Dispatch dimension registers loaded from memory and never written with zero; the code takes any load here, zero included.
// [R8] Conditional batch end after each dimension load ends the batch on zero.
// [R9] The guarded indirect dispatch is the last dispatch in its batch.
// [R10] Gated draw command is discarded while predicate bit is set.
// [R11] Predicate command derives new predicate bit from its control fields.
// [R12] Sources and data registers may be loaded before the predicate command.
// [R13] Loads from memory wait until earlier flushed stores have completed.
// [R14] Reset clears the predicate bit so draws are not discarded.
// [R15] Counters count one per event; a load replaces the value that cycle.
`timescale 1ns/1ps
`default_nettype none
module rcpc_ctrl #(
    parameter int NUM_STATS = 10
) (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // Command stream
    input wire logic I_CMD_VALID,
    input wire rcpc_pkg::rcpc_cmd_t I_CMD,
    input wire logic I_STORE_PENDING,
    output logic O_CMD_READY,
    // Pipeline events
    input wire logic [NUM_STATS-1:0] I_STAT_EVT,
    input wire logic [rcpc_pkg::NUM_STREAMS-1:0] I_SO_PRIM_EVT,
    input wire logic [rcpc_pkg::NUM_STREAMS-1:0] I_SO_NEED_EVT,
    // Register read port
    input wire logic [15:0] I_RD_ADDR,
    output logic [31:0] O_RD_DATA,
    // Pipeline controls
    output rcpc_pkg::rcpc_split_t O_SPLIT,
    output logic O_PRED_STATE,
    output logic O_BATCH_END,
    output logic O_DRAW_ISSUE,
    output logic O_DRAW_DISCARD,
    output logic O_DISPATCH_GO
);
    import rcpc_pkg::*;

    if (NUM_STATS < 1 || NUM_STATS > 16) begin : g_chk
        $error("NUM_STATS must be 1 to 16");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    rcpc_mode_t mode_reg, mode_next;
    logic [31:0] stat_reg [NUM_STATS];
    logic [31:0] stat_next [NUM_STATS];
    logic [31:0] so_reg [NUM_SO_SETS][NUM_STREAMS];
    logic [31:0] so_next [NUM_SO_SETS][NUM_STREAMS];
    logic [31:0] dim_reg [3];
    logic [31:0] dim_next [3];
    logic [31:0] src0_reg, src0_next, src1_reg, src1_next, pdata_reg, pdata_next;
    logic pred_reg, pred_next;
    logic [31:0] rd_reg, rd_next;
    logic bend_reg, bend_next, issue_reg, issue_next, disc_reg, disc_next, go_reg, go_next;
    logic cmd_ok, wr_en, cmp, ld;
    logic [31:0] wr_data;

    // Address of word idx above a base
    function automatic logic [15:0] reg_at(input logic [15:0] base, input int idx);
        reg_at = base + 16'(idx) * WORD_STEP;
    endfunction

    // Register read decode, shared by read port and register-to-register load
    function automatic logic [31:0] reg_read(input logic [15:0] a);
        reg_read = ZERO_WORD;
        if (a == FSPLIT_OFS) reg_read = {30'h0, mode_reg};
        if (a == PSRC0_OFS) reg_read = src0_reg;
        if (a == PSRC1_OFS) reg_read = src1_reg;
        if (a == PDATA_OFS) reg_read = pdata_reg;
        if (a == PRESULT_OFS) reg_read = {31'h0, pred_reg};
        if (a == DIM_X_OFS) reg_read = dim_reg[0];
        if (a == DIM_Y_OFS) reg_read = dim_reg[1];
        if (a == DIM_Z_OFS) reg_read = dim_reg[2];
        for (int i = 0; i < NUM_STATS; i++) begin
            if (a == reg_at(STAT_BASE, i)) reg_read = stat_reg[i];
        end
        for (int s = 0; s < NUM_STREAMS; s++) begin
            if (a == reg_at(SO_PRIM_BASE, s)) reg_read = so_reg[0][s];
            if (a == reg_at(SO_NEED_BASE, s)) reg_read = so_reg[1][s];
            if (a == reg_at(SO_OFS_BASE, s)) reg_read = so_reg[2][s];
        end
    endfunction

    // ----------------------------------------
    // Command acceptance
    // ----------------------------------------
    // Memory loads stall while flushed stores are still outstanding
    assign O_CMD_READY = !(I_CMD.op == OP_LOAD_MEM && I_STORE_PENDING); // [R13]

    always_comb begin
        cmd_ok = I_CMD_VALID && O_CMD_READY;
        wr_en = cmd_ok && (I_CMD.op == OP_LOAD_IMM || I_CMD.op == OP_LOAD_MEM || I_CMD.op == OP_LOAD_REG); // [R4]
        wr_data = (I_CMD.op == OP_LOAD_REG) ? reg_read(I_CMD.src_addr) : I_CMD.data;
    end

    // ----------------------------------------
    // Mode, dimension and predicate source registers
    // ----------------------------------------
    always_comb begin
        mode_next = mode_reg;
        dim_next = dim_reg;
        src0_next = src0_reg;
        src1_next = src1_reg;
        pdata_next = pdata_reg;
        if (wr_en && I_CMD.addr == FSPLIT_OFS) mode_next = rcpc_mode_t'(wr_data[1:0]); // [R1]
        // Zero is not filtered here; the batch-end guard keeps the dispatch away
        if (wr_en && I_CMD.addr == DIM_X_OFS) dim_next[0] = wr_data; // [R7]
        if (wr_en && I_CMD.addr == DIM_Y_OFS) dim_next[1] = wr_data;
        if (wr_en && I_CMD.addr == DIM_Z_OFS) dim_next[2] = wr_data;
        if (wr_en && I_CMD.addr == PSRC0_OFS) src0_next = wr_data; // [R12]
        if (wr_en && I_CMD.addr == PSRC1_OFS) src1_next = wr_data;
        if (wr_en && I_CMD.addr == PDATA_OFS) pdata_next = wr_data;
    end

    // Split mode decode feeds the pipeline units
    always_comb begin
        O_SPLIT.alt_frame = (mode_reg == MODE_ALTERNATE_FRAME); // [R1]
        O_SPLIT.split_frame = (mode_reg == MODE_SPLIT_FRAME) || (mode_reg == MODE_CHECKERBOARD);
        O_SPLIT.unit_checker = O_SPLIT.split_frame; // [R2]
        O_SPLIT.tiler_checker = (mode_reg == MODE_CHECKERBOARD); // [R2]
        O_SPLIT.scissor_split = (mode_reg == MODE_SPLIT_FRAME); // [R2]
    end

    // ----------------------------------------
    // Statistics counters
    // ----------------------------------------
    // A load wins over an event in the same cycle; the event is dropped
    always_comb begin
        for (int i = 0; i < NUM_STATS; i++) begin
            stat_next[i] = stat_reg[i] + 32'(I_STAT_EVT[i]); // [R3] [R15]
            if (wr_en && I_CMD.addr == reg_at(STAT_BASE, i)) stat_next[i] = wr_data; // [R15]
        end
        for (int s = 0; s < NUM_STREAMS; s++) begin
            so_next[0][s] = so_reg[0][s] + 32'(I_SO_PRIM_EVT[s]); // [R6]
            so_next[1][s] = so_reg[1][s] + 32'(I_SO_NEED_EVT[s]); // [R6]
            so_next[2][s] = so_reg[2][s];
            if (wr_en && I_CMD.addr == reg_at(SO_PRIM_BASE, s)) so_next[0][s] = wr_data;
            if (wr_en && I_CMD.addr == reg_at(SO_NEED_BASE, s)) so_next[1][s] = wr_data;
            if (wr_en && I_CMD.addr == reg_at(SO_OFS_BASE, s)) so_next[2][s] = wr_data;
        end
    end

    // ----------------------------------------
    // Predicate, draw gating, batch end, dispatch
    // ----------------------------------------
    always_comb begin
        cmp = I_CMD.pred.compare_sel ? (pdata_reg == ZERO_WORD) : (src0_reg == src1_reg);
        unique case (I_CMD.pred.load_op)
            PLOAD_KEEP: ld = pred_reg;
            PLOAD_TRUE: ld = cmp;
            PLOAD_INV: ld = !cmp;
            default: ld = pred_reg;
        endcase
        pred_next = pred_reg;
        if (cmd_ok && I_CMD.op == OP_PREDICATE) begin
            unique case (I_CMD.pred.combine_op)
                PCOMB_SET: pred_next = ld; // [R11]
                PCOMB_AND: pred_next = pred_reg & ld;
                PCOMB_OR: pred_next = pred_reg | ld;
                PCOMB_XOR: pred_next = pred_reg ^ ld;
            endcase
        end
        bend_next = cmd_ok && I_CMD.op == OP_COND_END && I_CMD.data == ZERO_WORD; // [R8]
        issue_next = cmd_ok && I_CMD.op == OP_DRAW && !(I_CMD.pred_gate && pred_reg); // [R10]
        disc_next = cmd_ok && I_CMD.op == OP_DRAW && I_CMD.pred_gate && pred_reg; // [R10]
        // Relies on the issuer ending the batch before a zero-sized dispatch
        go_next = cmd_ok && I_CMD.op == OP_DISPATCH; // [R9]
        rd_next = reg_read(I_RD_ADDR); // [R5]
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            mode_reg <= MODE_RESET; // [R1]
            pred_reg <= 1'b0; // [R14]
            dim_reg <= '{default: DIM_RESET};
            stat_reg <= '{default: ZERO_WORD};
            so_reg <= '{default: '{default: ZERO_WORD}};
            src0_reg <= ZERO_WORD;
            src1_reg <= ZERO_WORD;
            pdata_reg <= ZERO_WORD;
            rd_reg <= ZERO_WORD;
            bend_reg <= 1'b0;
            issue_reg <= 1'b0;
            disc_reg <= 1'b0;
            go_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            pred_reg <= pred_next;
            dim_reg <= dim_next;
            stat_reg <= stat_next;
            so_reg <= so_next;
            src0_reg <= src0_next;
            src1_reg <= src1_next;
            pdata_reg <= pdata_next;
            rd_reg <= rd_next;
            bend_reg <= bend_next;
            issue_reg <= issue_next;
            disc_reg <= disc_next;
            go_reg <= go_next;
        end
    end

    assign O_RD_DATA = rd_reg;
    assign O_PRED_STATE = pred_reg;
    assign O_BATCH_END = bend_reg;
    assign O_DRAW_ISSUE = issue_reg;
    assign O_DRAW_DISCARD = disc_reg;
    assign O_DISPATCH_GO = go_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // Checked at the release edge only: before the first edge the state is still unknown
    a_mode_reset: assert property (@(posedge I_CLK) $past(I_RST) && !I_RST |-> mode_reg == MODE_SINGLE) // [R1]
        else $error("mode not cleared by reset");
    a_split_tiler: assert property (@(posedge I_CLK) disable iff (I_RST) // [R2]
        mode_reg == MODE_SPLIT_FRAME |-> O_SPLIT.unit_checker && !O_SPLIT.tiler_checker && O_SPLIT.scissor_split)
        else $error("basic split decode wrong");
    a_stat_count: assert property (@(posedge I_CLK) disable iff (I_RST) // [R15]
        I_STAT_EVT[0] && !(wr_en && I_CMD.addr == STAT_BASE) |=> stat_reg[0] == $past(stat_reg[0]) + 32'h1)
        else $error("counter missed an event");
    a_stat_load: assert property (@(posedge I_CLK) disable iff (I_RST) // [R4]
        wr_en && I_CMD.addr == STAT_BASE |=> stat_reg[0] == $past(wr_data))
        else $error("counter load lost");
    a_read_any: assert property (@(posedge I_CLK) disable iff (I_RST) // [R5]
        I_RD_ADDR == STAT_BASE |=> O_RD_DATA == $past(stat_reg[0]))
        else $error("counter read wrong");
    // Back-to-back loads are legal, so the hold is only owed when no new load came
    a_so_stream: assert property (@(posedge I_CLK) disable iff (I_RST) // [R6]
        wr_en && I_CMD.addr == reg_at(SO_OFS_BASE, 3) |=> so_reg[2][3] == $past(wr_data)
        ##1 (so_reg[2][3] == $past(so_reg[2][3]) || $past(wr_en && I_CMD.addr == reg_at(SO_OFS_BASE, 3))))
        else $error("stream 3 offset not held");
    a_cond_end: assert property (@(posedge I_CLK) disable iff (I_RST) // [R8]
        cmd_ok && I_CMD.op == OP_COND_END |=> O_BATCH_END == ($past(I_CMD.data) == ZERO_WORD)
        ##1 (!O_BATCH_END || $past(cmd_ok && I_CMD.op == OP_COND_END)))
        else $error("batch end wrong");
    a_draw_gate: assert property (@(posedge I_CLK) disable iff (I_RST) // [R10]
        cmd_ok && I_CMD.op == OP_DRAW && I_CMD.pred_gate && pred_reg |=> O_DRAW_DISCARD && !O_DRAW_ISSUE)
        else $error("gated draw not discarded");
    a_pred_set: assert property (@(posedge I_CLK) disable iff (I_RST) // [R11]
        cmd_ok && I_CMD.op == OP_PREDICATE && I_CMD.pred.load_op == PLOAD_TRUE && I_CMD.pred.combine_op == PCOMB_SET
        |=> O_PRED_STATE == $past(cmp))
        else $error("predicate not loaded");
    // A stalled memory load must neither be taken nor reach its target register
    a_load_wait: assert property (@(posedge I_CLK) disable iff (I_RST) // [R13]
        I_CMD_VALID && I_CMD.op == OP_LOAD_MEM && I_CMD.addr == DIM_X_OFS && I_STORE_PENDING
        |-> !O_CMD_READY ##1 dim_reg[0] == $past(dim_reg[0]))
        else $error("memory load taken during flush");
    a_pred_reset: assert property (@(posedge I_CLK) $past(I_RST) && !I_RST |-> !O_PRED_STATE && !O_DRAW_DISCARD) // [R14]
        else $error("predicate not cleared");
endmodule // rcpc_ctrl
`default_nettype wire

/* File: pkg/rcpc_pkg.sv */
`default_nettype none
package rcpc_pkg;
    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam logic [15:0] FSPLIT_OFS = 16'h9038;
    localparam logic [15:0] STAT_BASE = 16'h2300;
    localparam logic [15:0] SO_PRIM_BASE = 16'h5200;
    localparam logic [15:0] SO_NEED_BASE = 16'h5240;
    localparam logic [15:0] SO_OFS_BASE = 16'h5280;
    localparam logic [15:0] DIM_X_OFS = 16'h2500;
    localparam logic [15:0] DIM_Y_OFS = 16'h2504;
    localparam logic [15:0] DIM_Z_OFS = 16'h2508;
    localparam logic [15:0] PSRC0_OFS = 16'h2400;
    localparam logic [15:0] PSRC1_OFS = 16'h2408;
    localparam logic [15:0] PDATA_OFS = 16'h2410;
    localparam logic [15:0] PRESULT_OFS = 16'h2418;
    localparam logic [15:0] WORD_STEP = 16'h0004;
    localparam int NUM_STREAMS = 4;
    localparam int NUM_SO_SETS = 3;
    localparam logic [31:0] ZERO_WORD = 32'h0;
    localparam logic [31:0] DIM_RESET = 32'h1;

    // ----------------------------------------
    // Frame split usage mode, field [1:0]
    // ----------------------------------------
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_ALTERNATE_FRAME = 2'h1,
        MODE_SPLIT_FRAME = 2'h2,
        MODE_CHECKERBOARD = 2'h3
    } rcpc_mode_t;
    localparam rcpc_mode_t MODE_RESET = MODE_SINGLE;

    // ----------------------------------------
    // Commands and predicate controls
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_NOP, OP_LOAD_IMM, OP_LOAD_MEM, OP_LOAD_REG,
        OP_COND_END, OP_PREDICATE, OP_DRAW, OP_DISPATCH
    } rcpc_op_t;
    localparam logic [1:0] PLOAD_KEEP = 2'h0;
    localparam logic [1:0] PLOAD_TRUE = 2'h1;
    localparam logic [1:0] PLOAD_INV = 2'h2;
    localparam logic [1:0] PCOMB_SET = 2'h0;
    localparam logic [1:0] PCOMB_AND = 2'h1;
    localparam logic [1:0] PCOMB_OR = 2'h2;
    localparam logic [1:0] PCOMB_XOR = 2'h3;
    typedef struct packed {
        logic [1:0] load_op;
        logic [1:0] combine_op;
        logic compare_sel; // 0: sources equal, 1: data word zero
    } rcpc_pred_ctl_t;
    typedef struct packed {
        rcpc_op_t op;
        logic [15:0] addr;
        logic [15:0] src_addr;
        logic [31:0] data;
        logic pred_gate;
        rcpc_pred_ctl_t pred;
    } rcpc_cmd_t;
    typedef struct packed {
        logic alt_frame;
        logic split_frame;
        logic unit_checker;
        logic tiler_checker;
        logic scissor_split;
    } rcpc_split_t;
endpackage
`default_nettype wire

/* File: tb/rcpc_store_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Memory side: flushed stores still in flight
// ----------------------------------------
module rcpc_store_model #(
    parameter int DELAY = 3
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Flush request from the issuer
    input wire logic i_kick,
    // Stores not yet complete
    output logic o_pending
);
    int cnt_reg;
    // A kick leaves stores outstanding for DELAY cycles, so loads must wait
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg <= 0;
        end else if (i_kick) begin
            cnt_reg <= DELAY;
        end else if (cnt_reg > 0) begin
            cnt_reg <= cnt_reg - 1;
        end
    end
    assign o_pending = (cnt_reg > 0);
endmodule // rcpc_store_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rcpc_pkg::*;
    localparam int NS = 6;
    logic I_CLK = 0, I_RST = 1, I_CMD_VALID = 0, kick = 0, rd_req = 0, pend;
    rcpc_cmd_t I_CMD = '0;
    logic [NS-1:0] I_STAT_EVT = '0;
    logic [3:0] I_SO_PRIM_EVT = '0, I_SO_NEED_EVT = '0, pv;
    logic [15:0] I_RD_ADDR = '0;
    logic [31:0] O_RD_DATA, seed = 32'h2305;
    rcpc_split_t O_SPLIT;
    logic O_CMD_READY, O_PRED_STATE, O_BATCH_END, O_DRAW_ISSUE, O_DRAW_DISCARD, O_DISPATCH_GO;
    logic [31:0] q_rd[$];
    logic [3:0] q_pl[$];
    // Predicate controls {load, combine, select}: every load, combine and select code is used
    logic [4:0] lo_tab[8] = '{5'h08, 5'h00, 5'h10, 5'h18, 5'h15, 5'h12, 5'h0e, 5'h17};
    logic pr_tab[8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int n_fail = 0, n_tests = 0, cs[NS], cp[4], cn[4], k;

    rcpc_ctrl #(.NUM_STATS(NS)) dut (.I_CLK(I_CLK), .I_RST(I_RST), .I_CMD_VALID(I_CMD_VALID),
        .I_CMD(I_CMD), .I_STORE_PENDING(pend), .O_CMD_READY(O_CMD_READY), .I_STAT_EVT(I_STAT_EVT),
        .I_SO_PRIM_EVT(I_SO_PRIM_EVT), .I_SO_NEED_EVT(I_SO_NEED_EVT), .I_RD_ADDR(I_RD_ADDR),
        .O_RD_DATA(O_RD_DATA), .O_SPLIT(O_SPLIT), .O_PRED_STATE(O_PRED_STATE),
        .O_BATCH_END(O_BATCH_END), .O_DRAW_ISSUE(O_DRAW_ISSUE), .O_DRAW_DISCARD(O_DRAW_DISCARD),
        .O_DISPATCH_GO(O_DISPATCH_GO));
    rcpc_store_model #(.DELAY(3)) u_store (.i_clk(I_CLK), .i_rst(I_RST), .i_kick(kick), .o_pending(pend));

    initial forever #5 I_CLK = ~I_CLK;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Command held until taken; expected pulse noted at the take edge
    task automatic issue(input rcpc_op_t op, input logic [15:0] a, input logic [15:0] s,
                         input logic [31:0] d, input logic [4:0] p, input logic g, input logic [3:0] e);
        @(negedge I_CLK);
        I_CMD = {op, a, s, d, g, p};
        I_CMD_VALID = 1;
        for (k = 0; k < 20; k++) begin
            @(posedge I_CLK);
            if (O_CMD_READY === 1'b1) break;
        end
        if (k == 20) begin
            n_fail++;
            conclude();
        end
        if (e != 0) q_pl.push_back(e);
        @(negedge I_CLK);
        I_CMD_VALID = 0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        @(negedge I_CLK);
        I_RD_ADDR = a;
        rd_req = 1;
        q_rd.push_back(e);
        @(negedge I_CLK);
        rd_req = 0;
    endtask

    // Watcher: oldest note against each result that shows up
    always @(posedge I_CLK) begin
        #1;
        if (rd_req) chk(O_RD_DATA, q_rd.pop_front());
        pv = {O_BATCH_END, O_DRAW_ISSUE, O_DRAW_DISCARD, O_DISPATCH_GO};
        // Case inequality so that an unknown pulse is caught, not skipped
        if (pv !== 4'h0) chk(32'(pv), q_pl.size() > 0 ? 32'(q_pl.pop_front()) : 32'hffff_ffff);
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge I_CLK);
        @(negedge I_CLK) I_RST = 0;
        rd(FSPLIT_OFS, 32'h0);
        rd(DIM_X_OFS, DIM_RESET);
        chk(32'(O_PRED_STATE), 32'h0);
        for (int m = 0; m < 4; m++) begin
            seed = lfsr(seed);
            issue(OP_LOAD_IMM, FSPLIT_OFS, 16'h0, {seed[31:2], 2'(m)}, 5'h0, 1'b0, 4'h0);
            rd(FSPLIT_OFS, 32'(m));
            chk(32'(O_SPLIT), {27'h0, m == 1, m > 1, m > 1, m == 3, m == 2});
        end
        // Random events; every pulse counted, no loads meanwhile
        repeat (40) begin
            @(negedge I_CLK);
            seed = lfsr(seed);
            {I_STAT_EVT, I_SO_PRIM_EVT, I_SO_NEED_EVT} = seed[NS+7:0];
            for (int i = 0; i < NS; i++) cs[i] += I_STAT_EVT[i];
            for (int i = 0; i < 4; i++) cp[i] += I_SO_PRIM_EVT[i];
            for (int i = 0; i < 4; i++) cn[i] += I_SO_NEED_EVT[i];
        end
        @(negedge I_CLK) {I_STAT_EVT, I_SO_PRIM_EVT, I_SO_NEED_EVT} = '0;
        for (int i = 0; i < NS; i++) rd(STAT_BASE + 16'(4 * i), cs[i]);
        for (int i = 0; i < 4; i++) rd(SO_PRIM_BASE + 16'(4 * i), cp[i]);
        for (int i = 0; i < 4; i++) rd(SO_NEED_BASE + 16'(4 * i), cn[i]);
        // Load on the same edge as an event: the load wins
        I_STAT_EVT = NS'(2);
        issue(OP_LOAD_IMM, STAT_BASE + 16'h4, 16'h0, seed, 5'h0, 1'b0, 4'h0);
        I_STAT_EVT = '0;
        rd(STAT_BASE + 16'h4, seed);
        issue(OP_LOAD_REG, STAT_BASE, STAT_BASE + 16'h4, 32'h0, 5'h0, 1'b0, 4'h0);
        rd(STAT_BASE, seed);
        issue(OP_LOAD_IMM, SO_OFS_BASE + 16'hc, 16'h0, ~seed, 5'h0, 1'b0, 4'h0);
        rd(SO_OFS_BASE + 16'hc, ~seed);
        rd(SO_OFS_BASE, 32'h0);
        rd(16'h0100, 32'h0);
        issue(OP_NOP, 16'h0, 16'h0, 32'h0, 5'h0, 1'b0, 4'h0);
        // X dimension load behind a flush, then the zero guard
        @(negedge I_CLK) kick = 1;
        @(negedge I_CLK) kick = 0;
        issue(OP_LOAD_MEM, DIM_X_OFS, 16'h0, 32'h5, 5'h0, 1'b0, 4'h0);
        chk(32'(k > 0), 32'h1);
        issue(OP_COND_END, DIM_X_OFS, 16'h0, 32'h5, 5'h0, 1'b0, 4'h0);
        issue(OP_DISPATCH, 16'h0, 16'h0, 32'h0, 5'h0, 1'b0, 4'h1);
        issue(OP_LOAD_MEM, DIM_Y_OFS, 16'h0, 32'h0, 5'h0, 1'b0, 4'h0);
        issue(OP_COND_END, DIM_Y_OFS, 16'h0, 32'h0, 5'h0, 1'b0, 4'h8);
        rd(DIM_X_OFS, 32'h5);
        // Predicate: gated draw dropped only while the bit is set
        issue(OP_DRAW, 16'h0, 16'h0, 32'h0, 5'h0, 1'b1, 4'h4);
        issue(OP_LOAD_IMM, PSRC0_OFS, 16'h0, seed, 5'h0, 1'b0, 4'h0);
        issue(OP_LOAD_IMM, PSRC1_OFS, 16'h0, seed, 5'h0, 1'b0, 4'h0);
        // Data word made nonzero so the data-zero compare yields false
        issue(OP_LOAD_MEM, PDATA_OFS, 16'h0, seed | 32'h1, 5'h0, 1'b0, 4'h0);
        for (int j = 0; j < 8; j++) begin
            issue(OP_PREDICATE, 16'h0, 16'h0, 32'h0, lo_tab[j], 1'b0, 4'h0);
            chk(32'(O_PRED_STATE), 32'(pr_tab[j]));
            issue(OP_DRAW, 16'h0, 16'h0, 32'h0, 5'h0, 1'b1, pr_tab[j] ? 4'h2 : 4'h4);
            issue(OP_DRAW, 16'h0, 16'h0, 32'h0, 5'h0, 1'b0, 4'h4);
        end
        rd(PRESULT_OFS, 32'(pr_tab[7]));
        repeat (3) @(negedge I_CLK);
        chk(32'(q_pl.size()), 32'h0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
